// File: hw/oad_operand_address_decoder.sv
// oad_operand_address_decoder: operand locator decode, pointer pairs,
// destination routing and an AXI4-Lite register slave
// assumes the core drives inst_* and ptr_upd_* on aclk
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module oad_operand_address_decoder (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready_ff,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready_ff,
    output logic [1:0]             bresp_ff,
    output logic                   bvalid_ff,
    input  wire logic              bready,
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready_ff,
    output logic [31:0]            rdata_ff,
    output logic [1:0]             rresp_ff,
    output logic                   rvalid_ff,
    input  wire logic              rready,
    input  wire logic              inst_valid,
    input  wire logic [15:0]       inst_word,
    input  wire logic              inst_mul,
    input  wire logic              inst_push,
    input  wire logic              inst_pop,
    input  wire logic              inst_loadh,
    input  wire logic              inst_loadl,
    input  wire logic              ptr_upd_valid,
    input  wire logic [1:0]        ptr_upd_sel,
    input  wire logic [7:0]        ptr_upd_low,
    input  wire logic              ptr_upd_carry,
    input  wire logic              ptr_upd_borrow,
    output logic                   dec_valid_ff,
    output oad_pkg::oad_fmt_t      dec_fmt_ff,
    output oad_pkg::oad_mode_t     dec_mode_ff,
    output logic [11:0]            ea_ff,
    output logic [11:0]            stack_addr_ff,
    output logic                   stack_use_ff,
    output logic                   wr_acc_ff,
    output logic                   wr_mem_ff,
    output logic                   wr_prod_hi_ff,
    output logic                   rd_zero_ff,
    output logic [1:0]             imm_dst_ff,
    output logic [7:0]             literal_ff,
    output logic [15:0]            jump_target_ff,
    output logic [2:0]             bit_sel_ff,
    output logic                   low_zone_ff
);
    // pointer pairs: indirect, data, soft stack, program address
    logic [15:0]        ptr_ff [4];
    logic [2:0]         page_ff;    // program page field
    logic               dec_en_ff;  // decode enable
    logic               aw_got_ff;  // write address held
    logic               w_got_ff;   // write data held
    logic [7:0]         wa_ff;      // held write address
    logic [31:0]        wd_ff;      // held write data
    logic [3:0]         ws_ff;      // held strobes
    logic [8:0]         operand_locator; // locator field of the word
    logic               take;       // instruction accepted
    logic               wr_do;      // register write this cycle
    logic               wr_ok;      // write address mapped
    logic               rd_ok;      // read address mapped
    logic [31:0]        rd_data;    // read mux
    logic [15:0]        sp_cur;     // stack pointer before update
    logic [15:0]        nxt_sp;     // stack pointer after push/pop
    logic [11:0]        nxt_ea;     // effective address
    logic               nxt_acc;
    logic               nxt_mem;
    logic               nxt_hi;
    logic               nxt_rsvd;   // reserved special location
    oad_pkg::oad_mode_t nxt_mode;
    oad_pkg::oad_fmt_t  nxt_fmt;

    // mode from the locator alone; all-zero wins over direct
    function automatic oad_pkg::oad_mode_t oad_loc_mode(
        input logic [8:0] f);
        if (f == 9'h000)
            return oad_pkg::OAD_M_IND;
        else if (f[8])
            return oad_pkg::OAD_M_OFS;
        else if (f[7])
            return oad_pkg::OAD_M_GLB;
        else
            return oad_pkg::OAD_M_SPR;
    endfunction : oad_loc_mode

    // format from the top three opcode bits
    function automatic oad_pkg::oad_fmt_t oad_fmt(
        input logic [15:0] w);
        unique case (w[15:13])
            oad_pkg::FMT_JMP:  return oad_pkg::OAD_F_JMP;
            oad_pkg::FMT_BIT:  return oad_pkg::OAD_F_BIT;
            oad_pkg::FMT_IMM:  return oad_pkg::OAD_F_IMM;
            oad_pkg::FMT_MISC: return oad_pkg::OAD_F_MISC;
            default:           return oad_pkg::OAD_F_TWO;
        endcase
    endfunction : oad_fmt

    // byte-lane merge for AXI strobes
    function automatic logic [15:0] oad_merge(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  s);
        logic [15:0] r;
        r = old;
        if (s[0])
            r[7:0] = d[7:0];
        if (s[1])
            r[15:8] = d[15:8];
        return r;
    endfunction : oad_merge

    assign operand_locator = inst_word[oad_pkg::LOC_W-1:0];
    assign take   = inst_valid && dec_en_ff;
    assign wr_do  = aw_got_ff && w_got_ff && !bvalid_ff;
    assign sp_cur = ptr_ff[oad_pkg::PTR_SP];

    // address and stack arithmetic
    always_comb begin
        nxt_mode = oad_loc_mode(operand_locator);
        nxt_fmt  = oad_fmt(inst_word);
        nxt_sp = sp_cur;
        if (inst_pop)
            nxt_sp = sp_cur + 16'h0001;
        else if (inst_push)
            nxt_sp = sp_cur - 16'h0001;
        unique case (nxt_mode)
            oad_pkg::OAD_M_IND: nxt_ea = ptr_ff[oad_pkg::PTR_IP][11:0];
            oad_pkg::OAD_M_SPR: nxt_ea = {5'h00, operand_locator[6:0]};
            oad_pkg::OAD_M_GLB: nxt_ea = oad_pkg::GLB_BASE
                                         | {5'h00, operand_locator[6:0]};
            oad_pkg::OAD_M_OFS: nxt_ea = (operand_locator[7]
                                ? sp_cur[11:0]
                                : ptr_ff[oad_pkg::PTR_DP][11:0])
                                + {5'h00, operand_locator[6:0]};
        endcase
    end

    assign nxt_rsvd = (nxt_mode == oad_pkg::OAD_M_SPR)
                      && (nxt_ea < oad_pkg::SPR_FIRST);

    // destination routing per format
    always_comb begin
        nxt_acc = 1'b0;
        nxt_mem = 1'b0;
        nxt_hi  = 1'b0;
        unique case (nxt_fmt)
            oad_pkg::OAD_F_TWO: begin
                if (inst_mul) begin
                    nxt_acc = 1'b1;
                    nxt_hi  = 1'b1;
                end else if (inst_word[oad_pkg::D_BIT]) begin
                    nxt_mem = 1'b1;
                end else begin
                    nxt_acc = 1'b1;
                end
            end
            oad_pkg::OAD_F_IMM: nxt_acc =
                inst_word[oad_pkg::IMM_DST_LSB +: 2]
                == oad_pkg::IMM_TO_ACC;
            oad_pkg::OAD_F_BIT: nxt_mem = 1'b1;
            oad_pkg::OAD_F_JMP: nxt_mem = 1'b0;
            oad_pkg::OAD_F_MISC: nxt_mem = 1'b0;
        endcase
        if (nxt_rsvd)
            nxt_mem = 1'b0;
    end

    // pointer pairs: bus, then core arithmetic, then decode wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++)
                ptr_ff[i] <= 16'h0000;
        end else begin
            if (wr_do && wr_ok && (wa_ff >= oad_pkg::A_IPTR)
                && (wa_ff <= oad_pkg::A_APTR))
                ptr_ff[wa_ff[3:2] - 2'h2] <=
                    oad_merge(ptr_ff[wa_ff[3:2] - 2'h2], wd_ff, ws_ff);
            if (ptr_upd_valid) begin
                ptr_ff[ptr_upd_sel][7:0]  <= ptr_upd_low;
                ptr_ff[ptr_upd_sel][15:8] <= ptr_ff[ptr_upd_sel][15:8]
                    + {7'h00, ptr_upd_carry} - {7'h00, ptr_upd_borrow};
            end
            if (take) begin
                if (inst_loadh)
                    ptr_ff[oad_pkg::PTR_DP][15:8] <= inst_word[7:0];
                if (inst_loadl)
                    ptr_ff[oad_pkg::PTR_DP][7:0] <= inst_word[7:0];
                // soft stack only, no return stack here
                if (inst_push || inst_pop)
                    ptr_ff[oad_pkg::PTR_SP] <= nxt_sp;
            end
        end
    end

    // decode results except dec_valid_ff, held until the next accepted word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dec_valid_ff   <= 1'b0;
            dec_fmt_ff     <= oad_pkg::OAD_F_TWO;
            dec_mode_ff    <= oad_pkg::OAD_M_IND;
            ea_ff          <= 12'h000;
            stack_addr_ff  <= 12'h000;
            stack_use_ff   <= 1'b0;
            wr_acc_ff      <= 1'b0;
            wr_mem_ff      <= 1'b0;
            wr_prod_hi_ff  <= 1'b0;
            rd_zero_ff     <= 1'b0;
            imm_dst_ff     <= 2'h0;
            literal_ff     <= 8'h00;
            jump_target_ff <= 16'h0000;
            bit_sel_ff     <= 3'h0;
            low_zone_ff    <= 1'b0;
        end else begin
            dec_valid_ff <= take;
            if (take) begin
                dec_fmt_ff    <= nxt_fmt;
                dec_mode_ff   <= nxt_mode;
                ea_ff         <= nxt_ea;
                stack_addr_ff <= inst_pop ? nxt_sp[11:0] : sp_cur[11:0];
                stack_use_ff  <= inst_push || inst_pop;
                wr_acc_ff     <= nxt_acc;
                wr_mem_ff     <= nxt_mem;
                wr_prod_hi_ff <= nxt_hi;
                rd_zero_ff    <= nxt_rsvd;
                imm_dst_ff    <= inst_word[oad_pkg::IMM_DST_LSB +: 2];
                literal_ff    <= inst_word[7:0];
                jump_target_ff <= {page_ff,
                                   inst_word[oad_pkg::JMP_W-1:0]};
                bit_sel_ff    <= inst_word[oad_pkg::BIT_LSB +: 3];
                // flag only; software must avoid this
                low_zone_ff   <= ((nxt_mode == oad_pkg::OAD_M_IND)
                                 || (nxt_mode == oad_pkg::OAD_M_OFS))
                                 && (nxt_ea < oad_pkg::LOW_LIMIT);
            end
        end
    end

    // control registers; only byte lane 0 matters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dec_en_ff <= oad_pkg::CTRL_RST;
            page_ff   <= 3'h0;
        end else if (wr_do && ws_ff[0]) begin
            if (wa_ff == oad_pkg::A_CTRL)
                dec_en_ff <= wd_ff[0];
            if (wa_ff == oad_pkg::A_PAGE)
                page_ff <= wd_ff[2:0];
        end
    end

    // writable map; status is read only
    assign wr_ok = (wa_ff <= oad_pkg::A_APTR);

    // read mux; unmapped reads give zero
    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        unique case ({araddr[7:2], 2'b00})
            oad_pkg::A_CTRL: rd_data = {31'h0000_0000, dec_en_ff};
            oad_pkg::A_PAGE: rd_data = {29'h0000_0000, page_ff};
            oad_pkg::A_IPTR: rd_data = {16'h0000, ptr_ff[0]};
            oad_pkg::A_DPTR: rd_data = {16'h0000, ptr_ff[1]};
            oad_pkg::A_SPTR: rd_data = {16'h0000, ptr_ff[2]};
            oad_pkg::A_APTR: rd_data = {16'h0000, ptr_ff[3]};
            oad_pkg::A_STAT: rd_data = {13'h0000, dec_fmt_ff,
                dec_mode_ff, low_zone_ff, rd_zero_ff, ea_ff};
            default: rd_ok = 1'b0;
        endcase
    end

    // AXI write: address and data in either order, one at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= oad_pkg::RESP_OKAY;
            wa_ff      <= 8'h00;
            wd_ff      <= 32'h0000_0000;
            ws_ff      <= 4'h0;
        end else begin
            if (awvalid && awready_ff) begin
                aw_got_ff  <= 1'b1;
                awready_ff <= 1'b0;
                wa_ff      <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready_ff) begin
                w_got_ff  <= 1'b1;
                wready_ff <= 1'b0;
                wd_ff     <= wdata;
                ws_ff     <= wstrb;
            end
            if (wr_do) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_ok ? oad_pkg::RESP_OKAY
                                   : oad_pkg::RESP_SLVERR;
            end
            // readies return only after the response is taken
            if (bvalid_ff && bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    // AXI read: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= oad_pkg::RESP_OKAY;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_data;
            rresp_ff   <= rd_ok ? oad_pkg::RESP_OKAY
                                : oad_pkg::RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // checks on the decode path and the bus
    AST_IND_EA: assert property (@(posedge aclk) disable iff (!aresetn)
        take && operand_locator == 9'h000 |=>
        ea_ff == $past(ptr_ff[0][11:0]))
        else $error("indirect address wrong");
    AST_SPR_EA: assert property (@(posedge aclk) disable iff (!aresetn)
        take && operand_locator[8:7] == 2'b00
        && operand_locator != 9'h000 |=>
        ea_ff == {5'h00, $past(inst_word[6:0])}
        && dec_mode_ff == oad_pkg::OAD_M_SPR)
        else $error("special direct address wrong");
    AST_GLB_EA: assert property (@(posedge aclk) disable iff (!aresetn)
        take && operand_locator[8:7] == 2'b01 |=>
        ea_ff == 12'h080 + {5'h00, $past(inst_word[6:0])})
        else $error("global direct address wrong");
    AST_DP_EA: assert property (@(posedge aclk) disable iff (!aresetn)
        take && operand_locator[8:7] == 2'b10 |=>
        ea_ff == $past(ptr_ff[1][11:0])
        + {5'h00, $past(operand_locator[6:0])})
        else $error("data pointer offset address wrong");
    AST_POP_SP: assert property (@(posedge aclk) disable iff (!aresetn)
        take && inst_pop && operand_locator[8:7] == 2'b11 |=>
        ea_ff == $past(sp_cur[11:0])
        + {5'h00, $past(operand_locator[6:0])}
        && stack_addr_ff == $past(sp_cur[11:0]) + 12'h001)
        else $error("pop address ordering wrong");
    AST_PUSH_SP: assert property (@(posedge aclk) disable iff (!aresetn)
        take && inst_push && !inst_pop |=>
        ptr_ff[2] == $past(sp_cur) - 16'h0001)
        else $error("push did not decrement stack");
    AST_MUL_DST: assert property (@(posedge aclk) disable iff (!aresetn)
        take && inst_mul && nxt_fmt == oad_pkg::OAD_F_TWO |=>
        wr_prod_hi_ff && wr_acc_ff && !wr_mem_ff)
        else $error("multiply routing wrong");
    AST_JMP_TGT: assert property (@(posedge aclk) disable iff (!aresetn)
        take && inst_word[15:13] == 3'h7 |=>
        jump_target_ff == {$past(page_ff), $past(inst_word[12:0])})
        else $error("jump target wrong");
    AST_DIR_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
        dec_valid_ff && (dec_mode_ff == oad_pkg::OAD_M_SPR
        || dec_mode_ff == oad_pkg::OAD_M_GLB) |-> ea_ff[11:8] == 4'h0)
        else $error("direct mode left low page");
    AST_CARRY: assert property (@(posedge aclk) disable iff (!aresetn)
        ptr_upd_valid && ptr_upd_sel == 2'h0 && ptr_upd_carry
        && !ptr_upd_borrow && !wr_do |=>
        ptr_ff[0][15:8] == $past(ptr_ff[0][15:8]) + 8'h01)
        else $error("pointer carry lost");
    AST_BHOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid_ff && !bready |=> bvalid_ff && $stable(bresp_ff))
        else $error("write response dropped");
    COV_POP_OFS: cover property (@(posedge aclk) disable iff (!aresetn)
        take && inst_pop && operand_locator[8:7] == 2'b11);
    COV_MUL: cover property (@(posedge aclk) disable iff (!aresetn)
        take && inst_mul ##1 wr_prod_hi_ff);
    COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_do ##1 bvalid_ff && bready);
endmodule : oad_operand_address_decoder

// File: hw/oad_pkg.sv
// oad_pkg: constants, register map and types for the operand decoder
// assumes one core clock; the core supplies opcode class strobes
package oad_pkg;
    typedef enum logic [1:0] {
        OAD_M_IND, OAD_M_SPR, OAD_M_GLB, OAD_M_OFS
    } oad_mode_t;
    typedef enum logic [2:0] {
        OAD_F_TWO, OAD_F_IMM, OAD_F_JMP, OAD_F_BIT, OAD_F_MISC
    } oad_fmt_t;
    localparam int         AXI_AW      = 8;
    localparam logic [7:0] A_CTRL      = 8'h00;
    localparam logic [7:0] A_PAGE      = 8'h04;
    localparam logic [7:0] A_IPTR      = 8'h08;
    localparam logic [7:0] A_DPTR      = 8'h0C;
    localparam logic [7:0] A_SPTR      = 8'h10;
    localparam logic [7:0] A_APTR      = 8'h14;
    localparam logic [7:0] A_STAT      = 8'h18;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int         LOC_W       = 9;
    localparam int         D_BIT       = 9;
    localparam int         BIT_LSB     = 9;
    localparam int         IMM_DST_LSB = 8;
    localparam int         JMP_W       = 13;
    localparam logic [2:0] FMT_JMP     = 3'h7;
    localparam logic [2:0] FMT_BIT     = 3'h6;
    localparam logic [2:0] FMT_IMM     = 3'h5;
    localparam logic [2:0] FMT_MISC    = 3'h4;
    localparam logic [1:0] IMM_TO_ACC  = 2'h0;
    localparam logic [11:0] GLB_BASE   = 12'h080;
    localparam logic [11:0] SPR_FIRST  = 12'h002;
    localparam logic [11:0] LOW_LIMIT  = 12'h020;
    localparam int         PTR_IP      = 0;
    localparam int         PTR_DP      = 1;
    localparam int         PTR_SP      = 2;
    localparam logic       CTRL_RST    = 1'b1;
endpackage : oad_pkg

// File: test/oad_core_model.sv
// oad_core_model: core side stand-in issuing instruction words
// assumes its tasks are called just after a rising edge of aclk
`timescale 1ns/1ps
module oad_core_model (
    input  wire logic   aclk,
    output logic        inst_valid,
    output logic [15:0] inst_word,
    output logic        inst_mul,
    output logic        inst_push,
    output logic        inst_pop,
    output logic        inst_loadh,
    output logic        inst_loadl,
    output logic        ptr_upd_valid,
    output logic [1:0]  ptr_upd_sel,
    output logic [7:0]  ptr_upd_low,
    output logic        ptr_upd_carry,
    output logic        ptr_upd_borrow
);
    // idle at time zero
    initial begin
        {inst_valid, inst_word} = 17'h0_0000;
        {inst_mul, inst_push, inst_pop, inst_loadh, inst_loadl} = 5'h00;
        {ptr_upd_valid, ptr_upd_sel, ptr_upd_low} = 11'h000;
        {ptr_upd_carry, ptr_upd_borrow} = 2'h0;
    end
    task automatic issue(input logic [15:0] w, input logic [4:0] c);
        {inst_valid, inst_word} <= {1'b1, w};
        {inst_mul, inst_push, inst_pop, inst_loadh, inst_loadl} <= c;
        @(posedge aclk);
        // inverted idle word, so a stale copy cannot pass
        {inst_valid, inst_word} <= {1'b0, ~w};
        {inst_mul, inst_push, inst_pop, inst_loadh, inst_loadl} <= 5'h00;
    endtask : issue
    // one low byte rewrite with carry and borrow flags
    task automatic upd(input logic [9:0] v, input logic [1:0] cb);
        {ptr_upd_valid, ptr_upd_sel, ptr_upd_low} <= {1'b1, v};
        {ptr_upd_carry, ptr_upd_borrow} <= cb;
        @(posedge aclk);
        {ptr_upd_valid, ptr_upd_carry, ptr_upd_borrow} <= 3'h0;
    endtask : upd
endmodule : oad_core_model

// File: test/operand_address_decoder_tb.sv
// operand_address_decoder_tb: directed checks of the operand decoder
// assumes the core model and the slave answer within 40 cycles
`timescale 1ns/1ps
module operand_address_decoder_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata_ff, d;
    logic [3:0] wstrb = 4'hF;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff, imm_dst_ff, ptr_upd_sel, r;
    logic inst_valid, inst_mul, inst_push, inst_pop, inst_loadh;
    logic inst_loadl, ptr_upd_valid, ptr_upd_carry, ptr_upd_borrow;
    logic dec_valid_ff, stack_use_ff, wr_acc_ff, wr_mem_ff;
    logic wr_prod_hi_ff, rd_zero_ff, low_zone_ff;
    logic [15:0] inst_word, jump_target_ff;
    logic [7:0] ptr_upd_low, literal_ff;
    logic [11:0] ea_ff, stack_addr_ff;
    logic [2:0] bit_sel_ff;
    oad_pkg::oad_fmt_t dec_fmt_ff;
    oad_pkg::oad_mode_t dec_mode_ff;
    int n_errors = 0, checks = 0;
    oad_operand_address_decoder dut_u (.*);
    oad_core_model core_u (.*);
    // 250 MHz core clock
    always #2 aclk = ~aclk;
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // a spent wait bound ends the run instead of hanging
    task automatic lim(int i);
        if (i >= 40) begin
            chk("handshake", 32'h0, 32'h1);
            results();
        end
    endtask : lim
    // address and data offered together, each dropped when taken
    task automatic wr(logic [7:0] a, logic [31:0] v);
        int i;
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
        i = 0;
        do begin
            @(posedge aclk);
            i++;
            if (awready_ff && awvalid) awvalid <= 1'b0;
            if (wready_ff && wvalid) wvalid <= 1'b0;
        end while (bvalid_ff !== 1'b1 && i < 40);
        r = bresp_ff;
        bready <= 1'b0;
        lim(i);
        // one edge between transfers, so no strobe is set twice at once
        @(posedge aclk);
    endtask : wr
    task automatic rd(logic [7:0] a);
        int i;
        {araddr, arvalid, rready} <= {a, 2'h3};
        i = 0;
        do begin
            @(posedge aclk);
            i++;
            if (arready_ff && arvalid) arvalid <= 1'b0;
        end while (rvalid_ff !== 1'b1 && i < 40);
        {d, r} = {rdata_ff, rresp_ff};
        rready <= 1'b0;
        lim(i);
        @(posedge aclk);
    endtask : rd
    // outputs land on the accepting edge, looked at 1 ns later
    // returns on the next edge, so the following drive starts on an edge
    task automatic dec(logic [15:0] w, logic [4:0] c, logic v = 1'b1);
        core_u.issue(w, c);
        #1;
        chk("dec_valid", dec_valid_ff, {31'h0000_0000, v});
        @(posedge aclk);
    endtask : dec
    task automatic t_regs;
        rd(8'h00);
        chk("ctrl", d, 32'h1);
        rd(8'h1C);
        chk("rdata_unmapped", d, 32'h0000_0000);
        chk("rresp", r, 2'h2);
        wr(8'h18, 32'h0000_FFFF);
        chk("bresp", r, 2'h2);
        // decode disabled: word ignored, stack pointer untouched
        wr(8'h00, 32'h0000_0000);
        dec(16'h0080, 5'h08, 1'b0);
        wr(8'h00, 32'h0000_0001);
        rd(8'h10);
        chk("sp_held", d, 32'h0000_0000);
    endtask : t_regs
    task automatic t_direct;
        dec(16'h007F, 5'h00);
        chk("spr", {dec_mode_ff, wr_acc_ff, wr_mem_ff, ea_ff},
            16'h607F);
        dec(16'h02A5, 5'h00);
        chk("glb", {dec_mode_ff, wr_acc_ff, wr_mem_ff, ea_ff},
            16'h90A5);
        dec(16'h0201, 5'h00);
        chk("rsvd", {rd_zero_ff, wr_mem_ff}, 2'h2);
    endtask : t_direct
    task automatic t_ind;
        wr(8'h08, 32'h0000_F385);
        chk("bresp_ok", r, 2'h0);
        dec(16'h0000, 5'h00);
        chk("ind", {dec_mode_ff, low_zone_ff, ea_ff}, 15'h0385);
        core_u.upd(10'h000, 2'h2);
        dec(16'h0000, 5'h00);
        chk("carry", ea_ff, 12'h400);
        core_u.upd(10'h0FF, 2'h1);
        rd(8'h08);
        chk("borrow", d, 32'h0000_F3FF);
    endtask : t_ind
    task automatic t_ofs;
        dec(16'h8003, 5'h02);
        dec(16'h8085, 5'h01);
        rd(8'h0C);
        chk("dp", d, 32'h0000_0385);
        dec(16'h017F, 5'h00);
        chk("dp_ofs", {dec_mode_ff, ea_ff}, 14'h3404);
        wr(8'h10, 32'h0000_F200);
        dec(16'h0184, 5'h04);
        chk("pop_ea", ea_ff, 12'h204);
        chk("pop_tos", {stack_use_ff, stack_addr_ff}, 13'h1201);
        dec(16'h0080, 5'h08);
        chk("push_tos", stack_addr_ff, 12'h201);
        rd(8'h10);
        chk("sp", d, 32'h0000_F200);
    endtask : t_ofs
    task automatic t_fmt;
        dec(16'h0212, 5'h10);
        chk("mul", {wr_prod_hi_ff, wr_acc_ff, wr_mem_ff}, 3'h6);
        wr(8'h04, 32'h5);
        dec(16'hE123, 5'h00);
        chk("jmp", {dec_fmt_ff, jump_target_ff}, 19'h2_A123);
        dec(16'hCA12, 5'h00);
        chk("bit", {dec_fmt_ff, bit_sel_ff, ea_ff}, 18'h1_D012);
        dec(16'hA07E, 5'h00);
        chk("imm", {dec_fmt_ff, imm_dst_ff, literal_ff}, 13'h047E);
        dec(16'h8000, 5'h00);
        chk("misc", dec_fmt_ff, 3'h4);
    endtask : t_fmt
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_direct();
        t_ind();
        t_ofs();
        t_fmt();
        results();
    end
endmodule : operand_address_decoder_tb
